// ===== hdl/prs_pkg.sv
// Purpose: Shared constants for power-up and reset sequencing ends
// Assumes: ref_clk at 10 MHz
// Notes: Times in ns, cycle counts derived
package prs_pkg;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned POWER_UP_INIT_WAIT_NS = 150000;
   localparam int unsigned RESET_LOW_PULSE_WIDTH_NS = 200;
   localparam int unsigned RESET_HIGH_TO_SELECT_GAP_NS = 200;
   localparam int unsigned RESET_LOW_TO_SELECT_GAP_NS = 400;
   localparam int unsigned SUPPLY_OFF_MIN_DURATION_NS = 50000;
   // Least times round up
   localparam int unsigned POWER_UP_INIT_WAIT_CYC =
      (POWER_UP_INIT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RESET_LOW_PULSE_WIDTH_CYC =
      (RESET_LOW_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RESET_HIGH_TO_SELECT_GAP_CYC =
      (RESET_HIGH_TO_SELECT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RESET_LOW_TO_SELECT_GAP_CYC =
      (RESET_LOW_TO_SELECT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SUPPLY_OFF_MIN_DURATION_CYC =
      (SUPPLY_OFF_MIN_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned CFG_W = 16;
   localparam logic [15:0] CFG0_RST = 16'h8F1F;
   localparam logic [15:0] CFG1_RST = 16'h0002;
   localparam int unsigned ROW_W = 13;
   localparam logic [12:0] ROW_RST = 13'h0000;
endpackage : prs_pkg

// ===== hdl/prs_link_if.sv
// Purpose: Reset and select wires between host and memory
// Assumes: One clock, host drives both wires
// Notes: Active low signals
`timescale 1ns/10ps
interface prs_link_if;
   logic reset_n;
   logic cs_n;
   modport host (output reset_n, output cs_n);
   modport mem (input reset_n, input cs_n);
endinterface : prs_link_if

// ===== hdl/prs_mem_end.sv
// Purpose: Memory-side power-up and reset sequencing
// Assumes: Link pins come from another domain
// Notes: rst_n models power-on; link reset is the pin
`timescale 1ns/10ps
module prs_mem_end #(
   parameter int unsigned INIT_WAIT_CYC = prs_pkg::POWER_UP_INIT_WAIT_CYC
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   prs_link_if.mem link,
   input wire logic dpd_enter,
   input wire logic cfg_wr,
   input wire logic cfg_sel,
   input wire logic [prs_pkg::CFG_W-1:0] cfg_wdata,
   output logic mem_ready,
   output logic refresh_on,
   output logic deep_pd,
   output logic select_violation,
   output logic [prs_pkg::CFG_W-1:0] cfg0,
   output logic [prs_pkg::CFG_W-1:0] cfg1,
   output logic [prs_pkg::ROW_W-1:0] refresh_row
);
   // Wait count must fit the counter
   if (INIT_WAIT_CYC < 1 || INIT_WAIT_CYC >= (1 << prs_pkg::CNT_W)) begin
      : g_bad_wait
      $error("INIT_WAIT_CYC out of range");
   end

   typedef enum logic [2:0] {
      PRS_M_HOLD = 3'b001,
      PRS_M_INIT = 3'b010,
      PRS_M_RUN = 3'b100
   } prs_mstate_t;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [2:0] rst_sync_r, rst_sync_nxt;
   logic [2:0] cs_sync_r, cs_sync_nxt;
   logic rst_lvl_r, rst_lvl_nxt;
   logic cs_lvl_r, cs_lvl_nxt;

   always_comb begin
      rst_sync_nxt = {rst_sync_r[1:0], link.reset_n};
      cs_sync_nxt = {cs_sync_r[1:0], link.cs_n};
      rst_lvl_nxt = rst_lvl_r;
      cs_lvl_nxt = cs_lvl_r;
      if (rst_sync_r[1] == rst_sync_r[2])
         rst_lvl_nxt = rst_sync_r[2];
      if (cs_sync_r[1] == cs_sync_r[2])
         cs_lvl_nxt = cs_sync_r[2];
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rst_sync_r <= 3'h0;
         cs_sync_r <= 3'h7;
         rst_lvl_r <= 1'b0;
         cs_lvl_r <= 1'b1;
      end else begin
         rst_sync_r <= rst_sync_nxt;
         cs_sync_r <= cs_sync_nxt;
         rst_lvl_r <= rst_lvl_nxt;
         cs_lvl_r <= cs_lvl_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   prs_mstate_t state_r, state_nxt;
   logic [prs_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic [prs_pkg::CFG_W-1:0] cfg0_r, cfg0_nxt, cfg1_r, cfg1_nxt;
   logic [prs_pkg::ROW_W-1:0] row_r, row_nxt;
   logic dpd_r, dpd_nxt;
   logic viol_r, viol_nxt;
   logic ready_r, ready_nxt;
   logic refr_r, refr_nxt;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      cfg0_nxt = cfg0_r;
      cfg1_nxt = cfg1_r;
      row_nxt = row_r;
      dpd_nxt = dpd_r;
      viol_nxt = 1'b0;
      refr_nxt = refr_r;
      if (!rst_lvl_r) begin
         state_nxt = PRS_M_HOLD;
         cnt_nxt = '0;
         cfg0_nxt = prs_pkg::CFG0_RST;
         cfg1_nxt = prs_pkg::CFG1_RST;
         row_nxt = prs_pkg::ROW_RST;
         dpd_nxt = 1'b0;
         refr_nxt = 1'b0;
         viol_nxt = !cs_lvl_r;
      end else begin
         refr_nxt = !dpd_r;
         if (refr_r)
            row_nxt = row_r + 1'b1;
         case (state_r)
            PRS_M_HOLD: begin
               state_nxt = PRS_M_INIT;
               cnt_nxt = '0;
            end
            PRS_M_INIT: begin
               viol_nxt = !cs_lvl_r;
               if (cnt_r == prs_pkg::CNT_W'(INIT_WAIT_CYC - 1))
                  state_nxt = PRS_M_RUN;
               else
                  cnt_nxt = cnt_r + 1'b1;
            end
            PRS_M_RUN: begin
               if (dpd_enter && cs_lvl_r)
                  dpd_nxt = 1'b1;
               else if (!cs_lvl_r)
                  dpd_nxt = 1'b0;
               if (cfg_wr && !cs_lvl_r && !dpd_r) begin
                  if (cfg_sel)
                     cfg1_nxt = cfg_wdata;
                  else
                     cfg0_nxt = cfg_wdata;
               end
            end
            default: state_nxt = PRS_M_HOLD;
         endcase
      end
      ready_nxt = (state_nxt == PRS_M_RUN) && !dpd_nxt;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_r <= PRS_M_HOLD;
         cnt_r <= '0;
         cfg0_r <= prs_pkg::CFG0_RST;
         cfg1_r <= prs_pkg::CFG1_RST;
         row_r <= prs_pkg::ROW_RST;
         dpd_r <= 1'b0;
         viol_r <= 1'b0;
         ready_r <= 1'b0;
         refr_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         cfg0_r <= cfg0_nxt;
         cfg1_r <= cfg1_nxt;
         row_r <= row_nxt;
         dpd_r <= dpd_nxt;
         viol_r <= viol_nxt;
         ready_r <= ready_nxt;
         refr_r <= refr_nxt;
      end
   end

   assign mem_ready = ready_r;
   assign refresh_on = refr_r;
   assign deep_pd = dpd_r;
   assign select_violation = viol_r;
   assign cfg0 = cfg0_r;
   assign cfg1 = cfg1_r;
   assign refresh_row = row_r;
endmodule : prs_mem_end

// ===== hdl/prs_host_end.sv
// Purpose: Host-side reset driver and ready gate
// Assumes: Same ref_clk as memory end
// Notes: Access request is honoured only when ready
`timescale 1ns/10ps
module prs_host_end #(
   parameter int unsigned INIT_WAIT_CYC = prs_pkg::POWER_UP_INIT_WAIT_CYC
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   prs_link_if.host link,
   input wire logic reset_req,
   input wire logic supply_dip,
   input wire logic access_req,
   output logic access_grant,
   output logic host_ready,
   output logic data_lost
);
   // Wait count must cover the select gap and fit the counter
   if (INIT_WAIT_CYC < prs_pkg::RESET_LOW_TO_SELECT_GAP_CYC ||
       INIT_WAIT_CYC >= (1 << prs_pkg::CNT_W)) begin : g_bad_wait
      $error("INIT_WAIT_CYC out of range");
   end

   typedef enum logic [2:0] {
      PRS_H_PULSE = 3'b001,
      PRS_H_WAIT = 3'b010,
      PRS_H_READY = 3'b100
   } prs_hstate_t;

   ////////////////////////////////////////////////////////////////////////
   // Reset pulse and ready timer
   prs_hstate_t state_r, state_nxt;
   logic [prs_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic [prs_pkg::CNT_W-1:0] wait_r, wait_nxt;
   logic lost_r, lost_nxt;
   logic grant_r, grant_nxt;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      wait_nxt = wait_r;
      lost_nxt = lost_r;
      grant_nxt = 1'b0;
      case (state_r)
         PRS_H_PULSE: begin
            if (cnt_r == prs_pkg::CNT_W'(
                prs_pkg::RESET_LOW_PULSE_WIDTH_CYC - 1)) begin
               state_nxt = PRS_H_WAIT;
               cnt_nxt = '0;
            end else
               cnt_nxt = cnt_r + 1'b1;
         end
         PRS_H_WAIT: begin
            if (reset_req || supply_dip) begin
               state_nxt = PRS_H_PULSE;
               cnt_nxt = '0;
               wait_nxt = prs_pkg::CNT_W'(
                  prs_pkg::RESET_LOW_TO_SELECT_GAP_CYC -
                  prs_pkg::RESET_LOW_PULSE_WIDTH_CYC);
               lost_nxt = 1'b1;
            end else if (cnt_r == wait_r - 1'b1)
               state_nxt = PRS_H_READY;
            else
               cnt_nxt = cnt_r + 1'b1;
         end
         PRS_H_READY: begin
            if (reset_req || supply_dip) begin
               state_nxt = PRS_H_PULSE;
               cnt_nxt = '0;
               wait_nxt = prs_pkg::CNT_W'(
                  prs_pkg::RESET_LOW_TO_SELECT_GAP_CYC -
                  prs_pkg::RESET_LOW_PULSE_WIDTH_CYC);
               lost_nxt = 1'b1;
            end else begin
               grant_nxt = access_req;
               if (access_req)
                  lost_nxt = 1'b0;
            end
         end
         default: state_nxt = PRS_H_PULSE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_r <= PRS_H_PULSE;
         cnt_r <= '0;
         wait_r <= prs_pkg::CNT_W'(INIT_WAIT_CYC);
         lost_r <= 1'b1;
         grant_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         wait_r <= wait_nxt;
         lost_r <= lost_nxt;
         grant_r <= grant_nxt;
      end
   end

   // Reset held low only in pulse state; select only on grant
   assign link.reset_n = (state_r != PRS_H_PULSE);
   assign link.cs_n = !grant_r;
   assign host_ready = (state_r == PRS_H_READY);
   assign access_grant = grant_r;
   assign data_lost = lost_r;
endmodule : prs_host_end

// ===== sim/prs_link_sva.sv
// Purpose: Link wire checks
// Assumes: INIT_WAIT_CYC as on both ends
// Notes: Plain link wires in
`timescale 1ns/10ps
module prs_link_sva #(
   parameter int unsigned INIT_WAIT_CYC = 8
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic reset_n,
   input wire logic cs_n
);
   logic [15:0] pu_r;
   logic [15:0] pu_nxt;
   always_comb begin
      pu_nxt = (pu_r == 16'hFFFF) ? pu_r : pu_r + 16'h0001;
   end
   always_ff @(posedge ref_clk) begin
      pu_r <= rst_n ? pu_nxt : 16'h0000;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   property p_powerup;
      (pu_r < INIT_WAIT_CYC + 3) |-> cs_n;
   endproperty
   a_powerup: assert property (p_powerup)
      else $error("select during power-up wait");
   property p_por_pulse;
      $rose(rst_n) |-> ##[0:3] !reset_n;
   endproperty
   a_por_pulse: assert property (p_por_pulse)
      else $error("no reset pulse after power-on");
   property p_width;
      $fell(reset_n) |-> !reset_n [*2];
   endproperty
   a_width: assert property (p_width)
      else $error("reset pulse too short");
   property p_rh_gap;
      $rose(reset_n) |-> cs_n [*2];
   endproperty
   a_rh_gap: assert property (p_rh_gap)
      else $error("select too soon after reset high");
   property p_rph_gap;
      $fell(reset_n) |-> cs_n [*4];
   endproperty
   a_rph_gap: assert property (p_rph_gap)
      else $error("select too soon after reset low");
   property p_no_sel;
      !reset_n |-> cs_n;
   endproperty
   a_no_sel: assert property (p_no_sel)
      else $error("select while reset low");
   property p_bounded;
      $fell(reset_n) |-> ##[2:8] reset_n;
   endproperty
   a_bounded: assert property (p_bounded)
      else $error("reset pulse never ends");
   property p_sel_edge;
      $fell(cs_n) |-> reset_n && $past(reset_n);
   endproperty
   a_sel_edge: assert property (p_sel_edge)
      else $error("select edge near reset");
endmodule : prs_link_sva

// ===== sim/psram_powerup_reset_sequencing_tb_top.sv
// Purpose: Both ends joined, driven by tasks
// Assumes: INIT_WAIT_CYC cut to 8
// Notes: Second link carries bench faults
`timescale 1ns/10ps
module psram_powerup_reset_sequencing_tb_top;
   localparam int unsigned IW = 8;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic reset_req = 1'b0;
   logic supply_dip = 1'b0;
   logic access_req = 1'b0;
   logic dpd_enter = 1'b0;
   logic cfg_wr = 1'b0;
   logic cfg_sel = 1'b0;
   logic [15:0] cfg_wdata = 16'h0000;
   logic access_grant, host_ready, data_lost, mem_ready, refresh_on;
   logic deep_pd, viol, viol_b;
   logic seen_a = 1'b0;
   logic seen_b = 1'b0;
   logic [15:0] cfg0, cfg1;
   logic [12:0] refresh_row;
   int n_mismatch = 0;
   int n_compared = 0;
   prs_link_if link ();
   prs_link_if link_b ();
   prs_host_end #(.INIT_WAIT_CYC(IW)) prs_host_end_i (.ref_clk(ref_clk),
      .rst_n(rst_n), .link(link), .reset_req(reset_req),
      .supply_dip(supply_dip), .access_req(access_req),
      .access_grant(access_grant), .host_ready(host_ready),
      .data_lost(data_lost));
   prs_mem_end #(.INIT_WAIT_CYC(IW)) prs_mem_end_i (.ref_clk(ref_clk),
      .rst_n(rst_n), .link(link), .dpd_enter(dpd_enter), .cfg_wr(cfg_wr),
      .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata), .mem_ready(mem_ready),
      .refresh_on(refresh_on), .deep_pd(deep_pd), .select_violation(viol),
      .cfg0(cfg0), .cfg1(cfg1), .refresh_row(refresh_row));
   prs_mem_end #(.INIT_WAIT_CYC(IW)) prs_mem_end_i2 (.ref_clk(ref_clk),
      .rst_n(rst_n), .link(link_b), .dpd_enter(dpd_enter),
      .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata),
      .mem_ready(), .refresh_on(), .deep_pd(), .select_violation(viol_b),
      .cfg0(), .cfg1(), .refresh_row());
   prs_link_sva #(.INIT_WAIT_CYC(IW)) prs_link_sva_i (.ref_clk(ref_clk),
      .rst_n(rst_n), .reset_n(link.reset_n), .cs_n(link.cs_n));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (viol === 1'b1) seen_a <= 1'b1;
      if (viol_b === 1'b1) seen_b <= 1'b1;
   end
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #10;
   endtask : step
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Bounded wait on one watched flag
   task automatic wait_for(input int k, input logic v);
      int i;
      logic [3:0] m;
      i = 0;
      do begin
         m = {link.reset_n, refresh_on, mem_ready, host_ready};
         if (m[k] !== v) step(1);
         i++;
      end while (m[k] !== v && i < 100);
      chk("wait", {15'h0000, v}, {15'h0000, m[k]});
   endtask : wait_for
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test
   initial begin
      #(3000 * 100);
      n_mismatch++;
      finish_test();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      link_b.reset_n = 1'b0;
      link_b.cs_n = 1'b1;
      step(5);
      rst_n = 1'b1;
      link_b.cs_n = 1'b0;
      access_req = 1'b1;
      chk("cfg0", 16'h8F1F, cfg0);
      chk("cfg1", 16'h0002, cfg1);
      chk("row", 16'h0000, {3'h0, refresh_row});
      chk("lost", 16'h0001, {15'h0000, data_lost});
      step(3);
      link_b.cs_n = 1'b1;
      chk("cs", 16'h0001, {15'h0000, link.cs_n});
      wait_for(0, 1'b1);
      wait_for(1, 1'b1);
      cfg_wr = 1'b1;
      cfg_wdata = 16'h1234;
      step(1);
      cfg_sel = 1'b1;
      cfg_wdata = 16'h00A5;
      step(2);
      access_req = 1'b0;
      cfg_wr = 1'b0;
      cfg_sel = 1'b0;
      chk("cfg0", 16'h1234, cfg0);
      chk("cfg1", 16'h00A5, cfg1);
      chk("lost", 16'h0000, {15'h0000, data_lost});
      // Let the raised select reach the memory end first
      step(6);
      dpd_enter = 1'b1;
      step(1);
      dpd_enter = 1'b0;
      step(2);
      chk("dpd", 16'h0001, {15'h0000, deep_pd});
      reset_req = 1'b1;
      step(1);
      reset_req = 1'b0;
      wait_for(3, 1'b0);
      wait_for(2, 1'b0);
      wait_for(2, 1'b1);
      chk("row", 16'h0000, {3'h0, refresh_row} & 16'hFFFE);
      chk("dpd", 16'h0000, {15'h0000, deep_pd});
      chk("cfg0", 16'h8F1F, cfg0);
      chk("cfg1", 16'h0002, cfg1);
      chk("lost", 16'h0001, {15'h0000, data_lost});
      wait_for(1, 1'b1);
      supply_dip = 1'b1;
      step(1);
      supply_dip = 1'b0;
      wait_for(3, 1'b0);
      wait_for(2, 1'b0);
      wait_for(2, 1'b1);
      wait_for(0, 1'b1);
      chk("viol_b", 16'h0001, {15'h0000, seen_b});
      chk("viol", 16'h0000, {15'h0000, seen_a});
      finish_test();
   end
endmodule : psram_powerup_reset_sequencing_tb_top
